// ---- rtl/cap_sense_pkg.sv ----
/*
  Package for the capacitive sensing control block: register indices,
  field positions, reset values and mode codes.
  Assumes a plain register port with byte-wide registers in the low bits.
*/
package cap_sense_pkg;

  // ----------------------------------------
  // Register map (word indices, byte address is four times)
  // ----------------------------------------
  localparam logic [3:0] IDX_A_CONTROL0 = 4'h0;
  localparam logic [3:0] IDX_A_CHANNEL = 4'h1;
  localparam logic [3:0] IDX_B_CONTROL0 = 4'h2;
  localparam logic [3:0] IDX_B_CHANNEL = 4'h3;
  localparam logic [3:0] IDX_TIMER_CTRL = 4'h4;
  localparam logic [3:0] IDX_SLEEP_STATUS = 4'h5;
  localparam logic [3:0] IDX_COUNT_A8 = 4'h6;
  localparam logic [3:0] IDX_COUNT_B8 = 4'h7;
  localparam logic [3:0] IDX_COUNT_A16_LO = 4'h8;
  localparam logic [3:0] IDX_COUNT_A16_HI = 4'h9;
  localparam logic [3:0] IDX_COUNT_B16_LO = 4'hA;
  localparam logic [3:0] IDX_COUNT_B16_HI = 4'hB;

  // ----------------------------------------
  // Control register 0 fields
  // ----------------------------------------
  localparam int BIT_ENABLE = 7;
  localparam int BIT_RANGE_MODE = 6;
  localparam int BIT_RANGE_HI = 3;
  localparam int BIT_RANGE_LO = 2;
  localparam int BIT_DIRECTION = 1;
  localparam int BIT_TIMER_CLK_SEL = 0;
  localparam logic [7:0] CONTROL0_WMASK = 8'hCD;
  localparam logic [7:0] CHANNEL_WMASK = 8'h0F;

  // Timer control register fields (per unit: external source, gated field, run)
  localparam int BIT_A_EXT_SRC = 0;
  localparam int BIT_B_EXT_SRC = 1;
  localparam int BIT_A_GATED_LO = 2;
  localparam int BIT_B_GATED_LO = 4;
  localparam int BIT_A8_RUN = 6;
  localparam int BIT_B8_RUN = 7;
  localparam logic [1:0] GATED_SRC_OSC = 2'h3;

  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Current range codes
  localparam logic [1:0] RANGE_OFF_NOISE = 2'h0;

  // Oscillator mode presented to the analog side
  typedef enum logic [3:0] {
    DRV_OFF = 4'b0001,
    DRV_NOISE = 4'b0010,
    DRV_CURRENT = 4'b0100,
    DRV_RSVD = 4'b1000
  } osc_mode_e;

endpackage : cap_sense_pkg

// ---- rtl/cap_sense_control.sv ----
/*
  Control and status logic for two capacitive sensing oscillator units.
  Assumes the analog oscillators return their direction level synchronous
  to mclk_in, that sleep_in is a level from the power controller, and that
  timer clock pins are sampled levels on mclk_in.
  Software keeps strobes one cycle long and word aligned; misaligned
  accesses are dropped without any effect.
*/
// Contract
// - An enabled unit outside low range code 00 keeps its oscillator running regardless of sleep.
// - Sixteen-bit timers clocked by the oscillator keep counting in sleep; evaluation needs wake.
// - The eight-bit sense timer does not count while the device sleeps.
// - Control 0 bit 7 enables the unit.
// - Control 0 bit 6 picks high range (external refs) or low range (internal refs).
// - In low range code 00 is off and 01/10/11 are low, medium, high current.
// - In high range code 00 is noise detection and 01/10/11 are the currents.
// - Control 0 bit 1 reads 1 while sourcing and 0 while sinking, read only.
// - With external source set, control 0 bit 0 picks oscillator (1) or clock pin (0).
// - With external source clear, the eight-bit timer runs on the instruction clock.
// - While enabled, channel code n connects electrode n of sixteen.
// - While disabled, the channel code is ignored and no electrode connects.
// - Control 0 bits 5-4 and channel register bits 7-4 read as zero.
// - All implemented control bits clear on every reset.
// - Unit A clocks the first timer of each kind, unit B the second.
// - The sixteen-bit timer uses the oscillator when its source field is 11.
module cap_sense_control
  import cap_sense_pkg::*;
#(
  parameter int ADDR_W = 6,
  parameter int INSTR_DIV = 4
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic sleep_in,
  input wire logic [1:0] osc_direction_in,
  input wire logic [1:0] timer_clock_input_pin_in,
  output logic [1:0] osc_run_out,
  output logic [1:0] reference_range_mode_out,
  output logic [3:0] osc_mode_a_out,
  output logic [3:0] osc_mode_b_out,
  output logic [1:0] current_level_a_out,
  output logic [1:0] current_level_b_out,
  output logic [15:0] electrode_a_out,
  output logic [15:0] electrode_b_out
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] control0_reg [2];
  logic [7:0] channel_reg [2];
  logic [7:0] timer_ctrl_reg;
  logic [7:0] count8_reg [2];
  logic [15:0] count16_reg [2];
  logic [1:0] direction_reg;
  logic [1:0] pin_prev_reg;
  logic [7:0] prescale_reg;
  logic [31:0] rdata_reg;
  logic [3:0] word_idx;
  logic addr_ok;
  logic instr_tick;
  logic [15:0] electrode_reg [2];
  logic [3:0] mode_reg [2];
  logic [1:0] level_reg [2];
  logic run_reg [2];
  logic high_range_reg [2];
  logic [31:0] rdata_next;
  logic wr_ok;
  logic rd_ok;

  // Aligned word decode; address bits below bit 2 must be zero or the access is dropped
  assign word_idx = addr_in[5:2];
  assign addr_ok = (addr_in[1:0] == 2'h0);
  // Misaligned strobes stop here, so no register below ever sees them
  assign wr_ok = wr_in && addr_ok;
  assign rd_ok = rd_in && addr_ok;

  // ----------------------------------------
  // Control register writes
  // ----------------------------------------
  // Direction bit is masked out so software cannot overwrite status
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      control0_reg[0] <= RESET_BYTE;
      control0_reg[1] <= RESET_BYTE;
      channel_reg[0] <= RESET_BYTE;
      channel_reg[1] <= RESET_BYTE;
      timer_ctrl_reg <= RESET_BYTE;
    end else if (wr_ok) begin
      unique case (word_idx)
        IDX_A_CONTROL0: control0_reg[0] <= wdata_in[7:0] & CONTROL0_WMASK;
        IDX_B_CONTROL0: control0_reg[1] <= wdata_in[7:0] & CONTROL0_WMASK;
        IDX_A_CHANNEL: channel_reg[0] <= wdata_in[7:0] & CHANNEL_WMASK;
        IDX_B_CHANNEL: channel_reg[1] <= wdata_in[7:0] & CHANNEL_WMASK;
        IDX_TIMER_CTRL: timer_ctrl_reg <= wdata_in[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Instruction clock tick (one pulse every INSTR_DIV cycles)
  // ----------------------------------------
  // Free running, so the tick phase does not depend on when a timer starts
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      prescale_reg <= 8'h00;
    end else if (prescale_reg == 8'(INSTR_DIV - 1)) begin
      prescale_reg <= 8'h00;
    end else begin
      prescale_reg <= prescale_reg + 8'h01;
    end
  end
  assign instr_tick = (prescale_reg == 8'(INSTR_DIV - 1));

  // ----------------------------------------
  // Direction status and edge tracking
  // ----------------------------------------
  // Oscillator only toggles while its unit runs, so a stopped unit holds
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      direction_reg <= 2'h0;
      pin_prev_reg <= 2'h0;
    end else begin
      direction_reg <= osc_direction_in;
      pin_prev_reg <= timer_clock_input_pin_in;
    end
  end

  // ----------------------------------------
  // Per-unit outputs, timers and counts
  // ----------------------------------------
  genvar u;
  generate
    for (u = 0; u < 2; u++) begin : g_unit
      logic enable;
      logic high_range;
      logic [1:0] range_code;
      logic ext_src;
      logic [1:0] gated_src;
      logic osc_active;
      logic osc_cycle;
      logic tick8;
      logic tick16;
      osc_mode_e mode;
      logic load8;
      logic clear16;
      logic freeze8;

      assign enable = control0_reg[u][BIT_ENABLE];
      assign high_range = control0_reg[u][BIT_RANGE_MODE];
      assign range_code = control0_reg[u][BIT_RANGE_HI:BIT_RANGE_LO];
      assign ext_src = timer_ctrl_reg[BIT_A_EXT_SRC + u];
      assign gated_src = timer_ctrl_reg[BIT_A_GATED_LO + 2*u +: 2];

      // Software access to the count words of this unit
      assign load8 = wr_ok && (word_idx == (IDX_COUNT_A8 + 4'(u)));
      assign clear16 = wr_ok && ((word_idx == (IDX_COUNT_A16_LO + 4'(2*u)))
                       || (word_idx == (IDX_COUNT_A16_HI + 4'(2*u))));

      // Oscillator state depends only on enable and range, never on sleep
      always_comb begin
        if (!enable) begin
          mode = DRV_OFF;
        end else if (range_code != RANGE_OFF_NOISE) begin
          mode = DRV_CURRENT;
        end else if (high_range) begin
          mode = DRV_NOISE;
        end else begin
          mode = DRV_OFF;
        end
      end
      assign osc_active = (mode != DRV_OFF);

      // One count per full cycle: sink-to-source transition of the oscillator
      assign osc_cycle = osc_active && osc_direction_in[u] && !direction_reg[u];

      // Stopped by software or by sleep; sleep wins over every source
      assign freeze8 = sleep_in || !timer_ctrl_reg[BIT_A8_RUN + u];

      // Eight-bit timer clock mux; frozen in sleep whatever the source
      always_comb begin
        if (freeze8) begin
          tick8 = 1'b0;
        end else if (!ext_src) begin
          tick8 = instr_tick;
        end else if (control0_reg[u][BIT_TIMER_CLK_SEL]) begin
          tick8 = osc_cycle;
        end else begin
          tick8 = timer_clock_input_pin_in[u] && !pin_prev_reg[u];
        end
      end

      // Sixteen-bit timer only counts the oscillator; it keeps going in sleep
      assign tick16 = (gated_src == GATED_SRC_OSC) && osc_cycle;

      // ----------------------------------------
      // Per-unit counters
      // ----------------------------------------
      // A software load wins over a tick in the same cycle, so a cleared
      // count never starts at one
      always_ff @(posedge mclk_in) begin
        if (reset_in) begin
          count8_reg[u] <= 8'h00;
        end else if (load8) begin
          count8_reg[u] <= wdata_in[7:0];
        end else if (tick8) begin
          count8_reg[u] <= count8_reg[u] + 8'h01;
        end
      end

      // Writing either half clears the whole count for a new time base;
      // the halves are not latched, so read them while the count is stopped
      always_ff @(posedge mclk_in) begin
        if (reset_in) begin
          count16_reg[u] <= 16'h0000;
        end else if (clear16) begin
          count16_reg[u] <= 16'h0000;
        end else if (tick16) begin
          count16_reg[u] <= count16_reg[u] + 16'h0001;
        end
      end

      // Electrode decode; nothing connected while disabled
      always_ff @(posedge mclk_in) begin
        if (reset_in) begin
          electrode_reg[u] <= 16'h0000;
        end else if (enable) begin
          electrode_reg[u] <= 16'h0001 << channel_reg[u][3:0];
        end else begin
          electrode_reg[u] <= 16'h0000;
        end
      end

      // Analog controls registered for glitch-free steering
      always_ff @(posedge mclk_in) begin
        if (reset_in) begin
          run_reg[u] <= 1'b0;
          high_range_reg[u] <= 1'b0;
          mode_reg[u] <= DRV_OFF;
          level_reg[u] <= 2'h0;
        end else begin
          run_reg[u] <= osc_active;
          high_range_reg[u] <= high_range;
          mode_reg[u] <= mode;
          level_reg[u] <= range_code;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Unit outputs
  // ----------------------------------------
  // Each unit keeps its own flip-flops; the flat ports are gathered here
  // so that no port is written by two processes
  assign electrode_a_out = electrode_reg[0];
  assign electrode_b_out = electrode_reg[1];
  assign osc_mode_a_out = mode_reg[0];
  assign osc_mode_b_out = mode_reg[1];
  assign current_level_a_out = level_reg[0];
  assign current_level_b_out = level_reg[1];
  assign osc_run_out = {run_reg[1], run_reg[0]};
  assign reference_range_mode_out = {high_range_reg[1], high_range_reg[0]};

  // ----------------------------------------
  // Read path: data stand one cycle after the strobe
  // ----------------------------------------
  // Unmapped addresses read zero; the port idles at zero between reads
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (rd_ok) begin
      unique case (word_idx)
        IDX_A_CONTROL0: rdata_next = {24'h0, control0_reg[0][7:2], direction_reg[0],
                                      control0_reg[0][0]};
        IDX_B_CONTROL0: rdata_next = {24'h0, control0_reg[1][7:2], direction_reg[1],
                                      control0_reg[1][0]};
        IDX_A_CHANNEL: rdata_next = {24'h0, channel_reg[0]};
        IDX_B_CHANNEL: rdata_next = {24'h0, channel_reg[1]};
        IDX_TIMER_CTRL: rdata_next = {24'h0, timer_ctrl_reg};
        IDX_SLEEP_STATUS: rdata_next = {31'h0, sleep_in};
        IDX_COUNT_A8: rdata_next = {24'h0, count8_reg[0]};
        IDX_COUNT_B8: rdata_next = {24'h0, count8_reg[1]};
        IDX_COUNT_A16_LO: rdata_next = {24'h0, count16_reg[0][7:0]};
        IDX_COUNT_A16_HI: rdata_next = {24'h0, count16_reg[0][15:8]};
        IDX_COUNT_B16_LO: rdata_next = {24'h0, count16_reg[1][7:0]};
        IDX_COUNT_B16_HI: rdata_next = {24'h0, count16_reg[1][15:8]};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Data stand for exactly one cycle, so the master needs no enable
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign rdata_out = rdata_reg;

endmodule : cap_sense_control

// ---- test/cap_sense_props.sv ----
/* Port checker for cap_sense_control, unit A plus the register port.
   Assumes binding to the top module with its ports matched by name. */
module cap_sense_props
  import cap_sense_pkg::*;
#(
  parameter int ADDR_W = 6
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic sleep_in,
  input wire logic [1:0] osc_run_out,
  input wire logic [1:0] reference_range_mode_out,
  input wire logic [3:0] osc_mode_a_out,
  input wire logic [1:0] current_level_a_out,
  input wire logic [15:0] electrode_a_out
);
  // ------------------------------
  // Relations at the ports
  // ------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  // Reset must win even over a pending write
  chk_reset_clears: assert property (disable iff (1'b0) reset_in |=>
    electrode_a_out == 16'h0 && osc_run_out == 2'h0) else $error("reset left outputs set");
  chk_read_idle: assert property (!rd_in |=> rdata_out == 32'h0) else $error("stray read data");
  chk_ctl_unimpl: assert property (rd_in && addr_in == '0 |=>
    rdata_out[31:8] == 24'h0 && rdata_out[5:4] == 2'h0) else $error("control0 gap bits set");
  chk_chan_unimpl: assert property (rd_in && addr_in == ADDR_W'(4) |=>
    rdata_out[31:4] == 28'h0) else $error("channel gap bits set");
  chk_low_off: assert property (!reference_range_mode_out[0]
    && current_level_a_out == 2'h0 |-> !osc_run_out[0] && osc_mode_a_out == DRV_OFF)
    else $error("low range 00 not off");
  chk_noise_mode: assert property (osc_run_out[0] && current_level_a_out == 2'h0
    |-> reference_range_mode_out[0] && osc_mode_a_out == DRV_NOISE) else $error("noise mode");
  chk_current_mode: assert property (osc_run_out[0] && current_level_a_out != 2'h0
    |-> osc_mode_a_out == DRV_CURRENT) else $error("current mode");
  chk_elec_onehot: assert property (osc_run_out[0] |-> $onehot(electrode_a_out))
    else $error("running unit without one electrode");
  // Sleep alone must never stop or start an oscillator
  chk_sleep_hold: assert property (sleep_in && !$past(wr_in) |=> $stable(osc_run_out))
    else $error("oscillator changed in sleep");
  cover property (osc_run_out[0] && sleep_in);
  cover property (osc_mode_a_out == DRV_NOISE);
  cover property (rd_in && addr_in == '0);
endmodule : cap_sense_props

// ---- test/cap_osc_model.sv ----
/* Behavioural oscillators and timer clock pins for both units.
   Assumes the run levels of the control block, single clock. */
module cap_osc_model #(
  parameter int HALF = 3,
  parameter int PIN_HALF = 5
) (
  input wire logic mclk_in,
  input wire logic [1:0] run_in,
  output logic [1:0] dir_out,
  output logic [1:0] pin_out
);
  int cnt = 0;
  int pcnt = 0;
  initial dir_out = 2'h0;
  initial pin_out = 2'h0;
  // A stopped oscillator holds its last direction, as the comparator does
  always @(posedge mclk_in) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    pcnt <= (pcnt == PIN_HALF - 1) ? 0 : pcnt + 1;
    if (cnt == HALF - 1) begin
      dir_out <= dir_out ^ run_in;
    end
    if (pcnt == PIN_HALF - 1) begin
      pin_out <= ~pin_out;
    end
  end
endmodule : cap_osc_model

// ---- test/cap_sense_control_bench.sv ----
/* Self-checking bench for cap_sense_control with the oscillator model.
   Assumes the package register map and timer control layout. */
module cap_sense_control_bench import cap_sense_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [5:0] addr_in = 6'h0;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic sleep_in = 1'b0;
  logic [31:0] rdata_out;
  logic [1:0] osc_direction_in, timer_clock_input_pin_in, osc_run_out;
  logic [1:0] reference_range_mode_out, current_level_a_out, current_level_b_out;
  logic [3:0] osc_mode_a_out, osc_mode_b_out;
  logic [15:0] electrode_a_out, electrode_b_out;
  logic [7:0] d;
  int err_total = 0;
  int total_checks = 0;
  int r;
  always #12.5 mclk_in = ~mclk_in;
  cap_sense_control u_dut (.mclk_in, .reset_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .sleep_in, .osc_direction_in, .timer_clock_input_pin_in, .osc_run_out,
    .reference_range_mode_out, .osc_mode_a_out, .osc_mode_b_out, .current_level_a_out,
    .current_level_b_out, .electrode_a_out, .electrode_b_out);
  cap_osc_model u_osc (.mclk_in, .run_in(osc_run_out), .dir_out(osc_direction_in),
    .pin_out(timer_clock_input_pin_in));
  // ------------------------------
  // Bus cycles and comparisons
  // ------------------------------
  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Oscillator phase against the clear is unknown, so counts get a window
  task automatic chk_rng(string nm, int lo, int hi, logic [7:0] got);
    total_checks++;
    if ($isunknown(got) || got < lo || got > hi) begin
      err_total++;
      $display("[FAIL] %s expected %0d..%0d seen %h", nm, lo, hi, got);
    end
  endtask : chk_rng
  task automatic wr(logic [5:0] a, logic [7:0] v);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= {24'h0, v};
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(logic [5:0] a);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out[7:0];
  endtask : rd
  // Direction bit masked: it follows the oscillator, not reset
  task automatic reg_zero();
    for (int i = 0; i < 4; i++) begin
      rd(6'(i * 4));
      chk("reset_value", 16'h0, {8'h0, d & 8'hFD});
    end
  endtask : reg_zero
  function automatic logic [3:0] mode_exp(logic rm, logic [1:0] c);
    return (c != 2'h0) ? DRV_CURRENT : (rm ? DRV_NOISE : DRV_OFF);
  endfunction : mode_exp
  task automatic conclude();
    if (err_total == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    r = $urandom(32'hCF04);
    repeat (8) @(posedge mclk_in);
    reset_in <= 1'b0;
    wr(6'h01, 8'h80);
    reg_zero();
    rd(6'h3C);
    chk("unmapped", 16'h0, {8'h0, d});
    // Every channel and every range/code pair, random filler bits
    for (int u = 0; u < 2; u++) begin
      for (int n = 0; n < 16; n++) begin
        r = $urandom;
        wr(6'(u * 8), {1'b1, n[2], r[5:4], n[1:0], r[1:0]});
        wr(6'(u * 8 + 4), {r[11:8], 4'(n)});
        rd(6'(u * 8 + 4));
        chk("channel_reg", 16'(n), {8'h0, d});
        rd(6'(u * 8));
        chk("control0_reg", {8'h0, 1'b1, n[2], 2'h0, n[1:0], 1'b0, r[0]},
          {8'h0, d & 8'hFD});
        chk("electrode", 16'h1 << n, u ? electrode_b_out : electrode_a_out);
        chk("osc_mode", 16'(mode_exp(n[2], n[1:0])),
          u ? osc_mode_b_out : osc_mode_a_out);
        chk("current_level", 16'(n[1:0]),
          16'(u ? current_level_b_out : current_level_a_out));
        chk("osc_run", 16'(n[2] | (n[1:0] != 2'h0)), 16'(osc_run_out[u]));
        chk("range_mode", 16'(n[2]), 16'(reference_range_mode_out[u]));
      end
      wr(6'(u * 8), 8'h4C);
      repeat (2) @(posedge mclk_in);
      #1;
      chk("off_electrode", 16'h0, u ? electrode_b_out : electrode_a_out);
      chk("off_run", 16'h0, 16'(osc_run_out[u]));
      rd(6'(u * 8));
      chk("direction", 16'(osc_direction_in[u]), 16'(d[1]));
    end
    // Eight-bit timer: instruction clock, oscillator, pin, then sleep
    wr(6'h00, 8'hCD);
    for (int k = 0; k < 4; k++) begin
      if (k == 2) wr(6'h00, 8'hCC);
      if (k == 3) begin
        @(posedge mclk_in);
        sleep_in <= 1'b1;
      end
      wr(6'h10, (k == 1 || k == 2) ? 8'h41 : 8'h40);
      wr(6'h18, 8'h00);
      repeat (k == 0 || k == 3 ? 40 : 60) @(posedge mclk_in);
      rd(6'h18);
      if (k == 0) chk_rng("count_instr", 9, 11, d);
      if (k == 1) chk_rng("count_osc", 8, 11, d);
      if (k == 2) chk_rng("count_pin", 5, 7, d);
      if (k == 3) chk("count_sleep", 16'h0, {8'h0, d});
    end
    // Sixteen-bit timers keep counting the oscillator in sleep
    for (int u = 0; u < 2; u++) begin
      wr(6'(u * 8), 8'hCC);
      wr(6'h10, u ? 8'h30 : 8'h0C);
      wr(6'(32 + u * 8), 8'h00);
      repeat (60) @(posedge mclk_in);
      rd(6'(32 + u * 8));
      chk_rng("count_16", 8, 11, d);
      rd(6'(36 + u * 8));
      chk("count_16_hi", 16'h0, {8'h0, d});
    end
    @(posedge mclk_in);
    sleep_in <= 1'b0;
    reset_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    reset_in <= 1'b0;
    reg_zero();
    conclude();
  end
endmodule : cap_sense_control_bench

bind cap_sense_control cap_sense_props #(.ADDR_W(ADDR_W)) u_props (.mclk_in, .reset_in,
  .addr_in, .wr_in, .rd_in, .rdata_out, .sleep_in, .osc_run_out, .reference_range_mode_out,
  .osc_mode_a_out, .current_level_a_out, .electrode_a_out);
